// *** dv/debug_host_model.sv ***
// Behavioural debug host that drives the mode pin and the serial commands.
`timescale 1ns/10ps
`default_nettype none
module debug_host_model (
  input wire logic clk_sys,
  output logic mode_select_debug_pin,
  output logic dbg_cmd_valid,
  output opmode_pkg::dbg_cmd_t dbg_cmd_code
);
  // ==========================================================
  // Idle state
  // The pin rests high through its pull-up and no command is offered.
  initial begin
    mode_select_debug_pin = 1'b1;
    dbg_cmd_valid = 1'b0;
    dbg_cmd_code = opmode_pkg::CMD_MEM;
  end

  // ==========================================================
  // Stimulus tasks
  // Holding the pin low across reset release asks for debug mode.
  task automatic hold_pin(input logic v);
    mode_select_debug_pin = v;
  endtask

  // One command is raised at the next falling edge and dropped at the one after.
  // The idle edge first keeps a drop and a raise out of one time step.
  // The code lines flip afterwards, so a stale code can never pass for a fresh one.
  task automatic send(input opmode_pkg::dbg_cmd_t c);
    @(negedge clk_sys);
    dbg_cmd_valid = 1'b1;
    dbg_cmd_code = c;
    @(negedge clk_sys);
    dbg_cmd_valid = 1'b0;
    dbg_cmd_code = opmode_pkg::dbg_cmd_t'(~c);
  endtask
endmodule
`default_nettype wire

// *** dv/tb_operating_mode_control.sv ***
// Self-checking testbench of the operating-mode controller.
`timescale 1ns/10ps
`default_nettype none
module tb_operating_mode_control;
  // ==========================================================
  // Signals
  typedef struct {opmode_pkg::dbg_cmd_t c; logic [3:0] ans; opmode_pkg::op_mode_t m;} row_t;
  logic clk_sys, sys_rst, mode_select_debug_pin, wait_exec, stop_exec, halt_to_debug_exec;
  logic breakpoint_hit, irq_request, reset_pin_asserted, key_wake_inputs, lowvolt_wake;
  logic adc_wake, periodic_wake_interrupt, dbg_cmd_valid, stop_enable_bit;
  logic internal_ref_stop_enable, external_ref_stop_enable, lowvolt_detect_enable;
  logic lowvolt_stop_enable, debug_mode_enable, adc_async_clk_enable, lcd_async_ref_enable;
  logic [13:0] cpu_pc, pc_load_addr_r;
  logic [2:0] periodic_wake_select;
  opmode_pkg::dbg_cmd_t dbg_cmd_code;
  opmode_pkg::op_mode_t mode_r;
  logic cpu_run_r, trace_step_r, pc_load_r, ilop_reset_r, pin_reset_r, periph_clk_en_r;
  logic clock_gen_on_r, regulator_full_r, debug_clk_en_r, pin_hold_r, wake_clk_en_r;
  logic ext_ref_on_r, adc_active_r, lcd_active_r, cmd_accept_r, cmd_reject_r;
  logic cmd_stat_err_r, mem_access_r;
  int n_errors, compares;
  row_t rows [10];
  wire [3:0] ans = {cmd_accept_r, cmd_reject_r, cmd_stat_err_r, mem_access_r};
  wire [7:0] units = {periph_clk_en_r, clock_gen_on_r, regulator_full_r, debug_clk_en_r,
                      pin_hold_r, ext_ref_on_r, adc_active_r, lcd_active_r};

  // ==========================================================
  // Clock and instances
  always #12.5 clk_sys = ~clk_sys;
  operating_mode_control operating_mode_control_inst (.*);
  debug_host_model debug_host_model_inst (.*);

  // ==========================================================
  // Helper tasks
  task automatic tick();
    @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic mode_is(input opmode_pkg::op_mode_t m);
    chk("mode", 16'(mode_r), 16'(m));
  endtask
  // A one-cycle pulse; on return the registered answer is visible.
  task automatic fire(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic send(input opmode_pkg::dbg_cmd_t c);
    debug_host_model_inst.send(c);
  endtask
  task automatic cfg(input logic [7:0] v);
    {stop_enable_bit, internal_ref_stop_enable, external_ref_stop_enable,
     lowvolt_detect_enable, lowvolt_stop_enable, debug_mode_enable,
     adc_async_clk_enable, lcd_async_ref_enable} = v;
  endtask
  task automatic wrap_up();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reset with a chosen pin level; the wait for boot to finish is bounded.
  task automatic do_reset(input logic pin, input opmode_pkg::op_mode_t m);
    debug_host_model_inst.hold_pin(pin);
    sys_rst = 1'b1;
    repeat (6) tick();
    mode_is(opmode_pkg::MODE_BOOT);
    chk("units", 16'(units), 16'h00F7);
    sys_rst = 1'b0;
    for (int i = 0; i < 4 && mode_r === opmode_pkg::MODE_BOOT; i++) tick();
    if (mode_r === opmode_pkg::MODE_BOOT) begin
      n_errors++;
      wrap_up();
    end
    debug_host_model_inst.hold_pin(1'b1);
    mode_is(m);
    chk("pc load", 16'({pc_load_r, pc_load_addr_r}), 16'({1'b1, 14'h3FFD}));
  endtask
  task automatic do_stop(input logic [13:0] pc, input logic [7:0] c, input logic [7:0] u);
    cpu_pc = pc;
    cfg(c);
    tick();
    fire(stop_exec);
    mode_is(opmode_pkg::MODE_STOP);
    chk("units", 16'(units), 16'(u));
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {wait_exec, stop_exec, halt_to_debug_exec, breakpoint_hit, irq_request} = 5'h00;
    {reset_pin_asserted, key_wake_inputs, lowvolt_wake, adc_wake} = 4'h0;
    periodic_wake_interrupt = 1'b0;
    periodic_wake_select = 3'h0;
    cpu_pc = 14'h0000;
    cfg(8'h00);
    n_errors = 0;
    compares = 0;
    rows = '{'{opmode_pkg::CMD_MEM, 4'h9, opmode_pkg::MODE_RUN},
             '{opmode_pkg::CMD_MEM_STAT, 4'h9, opmode_pkg::MODE_RUN},
             '{opmode_pkg::CMD_CPU_REG, 4'h4, opmode_pkg::MODE_RUN},
             '{opmode_pkg::CMD_TRACE, 4'h4, opmode_pkg::MODE_RUN},
             '{opmode_pkg::CMD_GO, 4'h4, opmode_pkg::MODE_RUN},
             '{opmode_pkg::CMD_HALT_TO_DEBUG_INSTRUCTION, 4'h8, opmode_pkg::MODE_DEBUG},
             '{opmode_pkg::CMD_CPU_REG, 4'h8, opmode_pkg::MODE_DEBUG},
             '{opmode_pkg::CMD_TRACE, 4'h8, opmode_pkg::MODE_DEBUG},
             '{opmode_pkg::CMD_MEM, 4'h9, opmode_pkg::MODE_DEBUG},
             '{opmode_pkg::CMD_GO, 4'h8, opmode_pkg::MODE_RUN}};
    do_reset(1'b1, opmode_pkg::MODE_RUN);
    chk("cpu run", 16'(cpu_run_r), 16'h0001);
    // Command classes in run and in debug mode, one idle cycle between them.
    foreach (rows[i]) begin
      send(rows[i].c);
      chk("answer", 16'(ans), 16'(rows[i].ans));
      mode_is(rows[i].m);
      if (rows[i].c == opmode_pkg::CMD_TRACE && rows[i].m == opmode_pkg::MODE_DEBUG)
        chk("trace", 16'(trace_step_r), 16'h0001);
      if (rows[i].m == opmode_pkg::MODE_DEBUG) chk("cpu run", 16'(cpu_run_r), 16'h0000);
    end
    // Instruction and breakpoint triggers of debug mode.
    fire(halt_to_debug_exec);
    mode_is(opmode_pkg::MODE_DEBUG);
    send(opmode_pkg::CMD_GO);
    fire(breakpoint_hit);
    mode_is(opmode_pkg::MODE_DEBUG);
    send(opmode_pkg::CMD_GO);
    // Wait: restricted commands, then an interrupt resumes one step on.
    cpu_pc = 14'h0123;
    fire(wait_exec);
    mode_is(opmode_pkg::MODE_WAIT);
    chk("cpu run", 16'(cpu_run_r), 16'h0000);
    send(opmode_pkg::CMD_MEM);
    chk("answer", 16'(ans), 16'h0004);
    send(opmode_pkg::CMD_MEM_STAT);
    chk("answer", 16'(ans), 16'h000A);
    fire(irq_request);
    mode_is(opmode_pkg::MODE_RUN);
    chk("pc load", 16'({pc_load_r, pc_load_addr_r}), 16'({1'b1, 14'h0124}));
    chk("units", 16'(units), 16'h00F7);
    fire(wait_exec);
    send(opmode_pkg::CMD_HALT_TO_DEBUG_INSTRUCTION);
    mode_is(opmode_pkg::MODE_DEBUG);
    send(opmode_pkg::CMD_GO);
    // Stop while disabled forces the illegal-opcode reset.
    fire(stop_exec);
    chk("ilop", 16'(ilop_reset_r), 16'h0001);
    mode_is(opmode_pkg::MODE_RUN);
    // Stop with detector kept; periodic wake is off, a key wakes.
    do_stop(14'h0200, 8'hDA, 8'h6A);
    send(opmode_pkg::CMD_MEM);
    chk("answer", 16'(ans), 16'h0000);
    periodic_wake_interrupt = 1'b1;
    repeat (2) tick();
    mode_is(opmode_pkg::MODE_STOP);
    chk("wake clk", 16'(wake_clk_en_r), 16'h0000);
    periodic_wake_interrupt = 1'b0;
    fire(key_wake_inputs);
    mode_is(opmode_pkg::MODE_RUN);
    chk("pc load", 16'({pc_load_r, pc_load_addr_r}), 16'({1'b1, 14'h0201}));
    // The detector and converter wake levels end stop as well.
    do_stop(14'h0220, 8'hD3, 8'h08);
    fire(lowvolt_wake);
    mode_is(opmode_pkg::MODE_RUN);
    chk("pc load", 16'({pc_load_r, pc_load_addr_r}), 16'({1'b1, 14'h0221}));
    do_stop(14'h0230, 8'hD3, 8'h08);
    fire(adc_wake);
    mode_is(opmode_pkg::MODE_RUN);
    chk("pc load", 16'({pc_load_r, pc_load_addr_r}), 16'({1'b1, 14'h0231}));
    // Stop with debug kept: status error, then the background command wakes.
    do_stop(14'h0210, 8'hA7, 8'h7C);
    send(opmode_pkg::CMD_MEM_STAT);
    chk("answer", 16'(ans), 16'h000A);
    send(opmode_pkg::CMD_HALT_TO_DEBUG_INSTRUCTION);
    mode_is(opmode_pkg::MODE_DEBUG);
    send(opmode_pkg::CMD_GO);
    // Deep stop, woken by the periodic interrupt once it is selected.
    do_stop(14'h0300, 8'hD3, 8'h08);
    periodic_wake_select = 3'h2;
    tick();
    chk("wake clk", 16'(wake_clk_en_r), 16'h0001);
    fire(periodic_wake_interrupt);
    chk("pc load", 16'({pc_load_r, pc_load_addr_r}), 16'({1'b1, 14'h0301}));
    // Reset pin in stop, then a reset into debug mode.
    do_stop(14'h0310, 8'hD3, 8'h08);
    reset_pin_asserted = 1'b1;
    tick();
    chk("pin reset", 16'(pin_reset_r), 16'h0001);
    reset_pin_asserted = 1'b0;
    do_reset(1'b0, opmode_pkg::MODE_DEBUG);
    chk("cpu run", 16'(cpu_run_r), 16'h0000);
    send(opmode_pkg::CMD_CPU_REG);
    chk("answer", 16'(ans), 16'h0008);
    wrap_up();
  end
endmodule
`default_nettype wire

// *** hdl/debug_cmd_gate.sv ***
// Combinational admission check of debug commands against the current mode.
`timescale 1ns/10ps
`default_nettype none
module debug_cmd_gate (
  mode_cmd_if.gate cif
);

  // ==========================================================
  // Command classes
  function automatic logic is_nonintrusive(input opmode_pkg::dbg_cmd_t c);
    is_nonintrusive = (c == opmode_pkg::CMD_MEM) || (c == opmode_pkg::CMD_MEM_STAT) ||
                      (c == opmode_pkg::CMD_HALT_TO_DEBUG_INSTRUCTION);
  endfunction

  wire logic nonintr;
  wire logic low_power;
  wire logic lp_ok;
  wire logic in_run;
  wire logic in_dbg;
  wire logic heard;

  // Commands in stop are only heard while the debug clocks stay alive;
  // otherwise the front end cannot even see them, so nothing answers.
  assign nonintr = is_nonintrusive(cif.cmd_code);
  assign in_run = (cif.mode == opmode_pkg::MODE_RUN);
  assign in_dbg = (cif.mode == opmode_pkg::MODE_DEBUG);
  assign low_power = (cif.mode == opmode_pkg::MODE_WAIT) ||
                     ((cif.mode == opmode_pkg::MODE_STOP) && cif.dbg_alive);
  assign lp_ok = (cif.cmd_code == opmode_pkg::CMD_HALT_TO_DEBUG_INSTRUCTION) ||
                 (cif.cmd_code == opmode_pkg::CMD_MEM_STAT);
  assign heard = cif.cmd_valid && (in_run || in_dbg || low_power);

  // Answers: accept, refuse, or accept with the stop/wait error.
  assign cif.accept = heard && (in_dbg || (in_run && nonintr) ||
                      (low_power && lp_ok));
  assign cif.reject = heard && !cif.accept;
  assign cif.stat_err = cif.accept && low_power &&
                        (cif.cmd_code == opmode_pkg::CMD_MEM_STAT);

endmodule
`default_nettype wire

// *** hdl/mode_cmd_if.sv ***
// Interface between the mode controller and its debug command gate.
`timescale 1ns/10ps
`default_nettype none
interface mode_cmd_if;
  logic cmd_valid;
  opmode_pkg::dbg_cmd_t cmd_code;
  opmode_pkg::op_mode_t mode;
  logic dbg_alive;
  logic accept;
  logic reject;
  logic stat_err;

  // The controller drives the request and the mode, the gate answers.
  modport ctrl (output cmd_valid, output cmd_code, output mode, output dbg_alive,
                input accept, input reject, input stat_err);
  modport gate (input cmd_valid, input cmd_code, input mode, input dbg_alive,
                output accept, output reject, output stat_err);
endinterface
`default_nettype wire

// *** hdl/operating_mode_control.sv ***
// Operating-mode controller: boot mode choice, wait, stop and debug mode.
`timescale 1ns/10ps
`default_nettype none

module operating_mode_control #(
  parameter int PC_W = opmode_pkg::PC_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic mode_select_debug_pin,
  input wire logic [PC_W-1:0] cpu_pc,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic halt_to_debug_exec,
  input wire logic breakpoint_hit,
  input wire logic irq_request,
  input wire logic reset_pin_asserted,
  input wire logic key_wake_inputs,
  input wire logic lowvolt_wake,
  input wire logic adc_wake,
  input wire logic periodic_wake_interrupt,
  input wire logic dbg_cmd_valid,
  input wire opmode_pkg::dbg_cmd_t dbg_cmd_code,
  input wire logic stop_enable_bit,
  input wire logic internal_ref_stop_enable,
  input wire logic external_ref_stop_enable,
  input wire logic lowvolt_detect_enable,
  input wire logic lowvolt_stop_enable,
  input wire logic [2:0] periodic_wake_select,
  input wire logic debug_mode_enable,
  input wire logic adc_async_clk_enable,
  input wire logic lcd_async_ref_enable,
  output opmode_pkg::op_mode_t mode_r,
  output logic cpu_run_r,
  output logic trace_step_r,
  output logic pc_load_r,
  output logic [PC_W-1:0] pc_load_addr_r,
  output logic ilop_reset_r,
  output logic pin_reset_r,
  output logic periph_clk_en_r,
  output logic clock_gen_on_r,
  output logic regulator_full_r,
  output logic debug_clk_en_r,
  output logic pin_hold_r,
  output logic wake_clk_en_r,
  output logic ext_ref_on_r,
  output logic adc_active_r,
  output logic lcd_active_r,
  output logic cmd_accept_r,
  output logic cmd_reject_r,
  output logic cmd_stat_err_r,
  output logic mem_access_r
);

  // ==========================================================
  // Command gate
  mode_cmd_if cif ();

  debug_cmd_gate debug_cmd_gate_inst (
    .cif (cif)
  );

  assign cif.cmd_valid = dbg_cmd_valid;
  assign cif.cmd_code = dbg_cmd_code;
  assign cif.mode = mode_r;

  // ==========================================================
  // Stop configuration captured at the moment stop is entered
  logic icg_keep_r;
  logic icg_keep_nxt;
  logic dbg_keep_r;
  logic dbg_keep_nxt;
  logic lvd_keep_r;
  logic lvd_keep_nxt;
  logic [PC_W-1:0] pc_hold_r;
  logic [PC_W-1:0] pc_hold_nxt;
  opmode_pkg::op_mode_t mode_nxt;
  assign cif.dbg_alive = dbg_keep_r;

  wire logic lvd_both;
  wire logic halt_to_debug_instruction_ok;
  wire logic go_ok;
  wire logic trace_ok;
  wire logic run_to_dbg;
  wire logic stop_wake;
  wire logic pwake_live;
  wire logic stopping;
  wire logic in_stop;
  wire logic [PC_W-1:0] pc_next;

  // The detector must be enabled in stop before entry; only the value
  // seen at the stop instruction counts for the whole stop period.
  assign lvd_both = lowvolt_detect_enable && lowvolt_stop_enable;
  assign halt_to_debug_instruction_ok = cif.accept && (dbg_cmd_code == opmode_pkg::CMD_HALT_TO_DEBUG_INSTRUCTION);
  assign go_ok = cif.accept && (dbg_cmd_code == opmode_pkg::CMD_GO);
  assign trace_ok = cif.accept && (dbg_cmd_code == opmode_pkg::CMD_TRACE);
  assign run_to_dbg = halt_to_debug_exec || breakpoint_hit || halt_to_debug_instruction_ok;
  assign pwake_live = periodic_wake_interrupt &&
                      (periodic_wake_select != opmode_pkg::PWAKE_OFF);
  assign stop_wake = key_wake_inputs || lowvolt_wake || adc_wake || pwake_live;
  assign stopping = (mode_r == opmode_pkg::MODE_RUN) && !run_to_dbg && !wait_exec &&
                    stop_exec && stop_enable_bit;
  assign in_stop = (mode_nxt == opmode_pkg::MODE_STOP);
  assign pc_next = pc_hold_r + opmode_pkg::PC_STEP;

  // ==========================================================
  // Mode sequencing. Debug triggers win over wait and stop in run, and a
  // background command wins over an interrupt in the same cycle, so the
  // host never loses control of a core that it has just asked to halt.
  always_comb begin
    mode_nxt = mode_r;
    pc_hold_nxt = pc_hold_r;
    icg_keep_nxt = icg_keep_r;
    dbg_keep_nxt = dbg_keep_r;
    lvd_keep_nxt = lvd_keep_r;
    case (mode_r)
      opmode_pkg::MODE_BOOT: begin
        if (mode_select_debug_pin) begin
          mode_nxt = opmode_pkg::MODE_RUN;
        end else begin
          mode_nxt = opmode_pkg::MODE_DEBUG;
        end
      end
      opmode_pkg::MODE_RUN: begin
        if (run_to_dbg) begin
          mode_nxt = opmode_pkg::MODE_DEBUG;
        end else if (wait_exec) begin
          mode_nxt = opmode_pkg::MODE_WAIT;
          pc_hold_nxt = cpu_pc;
        end else if (stopping) begin
          mode_nxt = opmode_pkg::MODE_STOP;
          pc_hold_nxt = cpu_pc;
          icg_keep_nxt = internal_ref_stop_enable && lvd_both;
          dbg_keep_nxt = debug_mode_enable;
          lvd_keep_nxt = lvd_both;
        end
      end
      opmode_pkg::MODE_DEBUG: begin
        if (go_ok) begin
          mode_nxt = opmode_pkg::MODE_RUN;
        end
      end
      opmode_pkg::MODE_WAIT: begin
        if (halt_to_debug_instruction_ok) begin
          mode_nxt = opmode_pkg::MODE_DEBUG;
        end else if (irq_request) begin
          mode_nxt = opmode_pkg::MODE_RUN;
        end
      end
      opmode_pkg::MODE_STOP: begin
        if (reset_pin_asserted) begin
          mode_nxt = opmode_pkg::MODE_STOP;
        end else if (halt_to_debug_instruction_ok) begin
          mode_nxt = opmode_pkg::MODE_DEBUG;
        end else if (stop_wake) begin
          mode_nxt = opmode_pkg::MODE_RUN;
        end
      end
      default: begin
        mode_nxt = opmode_pkg::MODE_BOOT;
      end
    endcase
  end

  // ==========================================================
  // Program counter loads: reset address at boot, held PC plus one
  // when an interrupt ends wait or stop. Debug entry from run, wait or stop loads nothing.
  wire logic load_boot;
  wire logic load_resume;
  wire logic [PC_W-1:0] pc_load_nxt;

  assign load_boot = (mode_r == opmode_pkg::MODE_BOOT);
  assign load_resume = ((mode_r == opmode_pkg::MODE_WAIT) ||
                        (mode_r == opmode_pkg::MODE_STOP)) &&
                       (mode_nxt == opmode_pkg::MODE_RUN);
  assign pc_load_nxt = load_boot ? opmode_pkg::RESET_PC :
                       (load_resume ? pc_next : pc_load_addr_r);

  // ==========================================================
  // Unit enables for the coming cycle. Outside stop everything stays
  // powered; in stop clock generator, regulator and debug clock use captured enables, external reference a live one, converter and LCD both.
  wire logic cpu_run_nxt;
  wire logic clock_gen_nxt;
  wire logic reg_full_nxt;
  wire logic dbg_clk_nxt;
  wire logic ext_ref_nxt;
  wire logic adc_nxt;
  wire logic lcd_nxt;

  assign cpu_run_nxt = (mode_nxt == opmode_pkg::MODE_RUN);
  assign clock_gen_nxt = !in_stop || icg_keep_nxt || dbg_keep_nxt;
  assign reg_full_nxt = !in_stop || dbg_keep_nxt || lvd_keep_nxt;
  assign dbg_clk_nxt = !in_stop || dbg_keep_nxt;
  assign ext_ref_nxt = !in_stop || external_ref_stop_enable;
  assign adc_nxt = !in_stop || (adc_async_clk_enable && lvd_keep_nxt);
  assign lcd_nxt = !in_stop || (lcd_async_ref_enable && lvd_keep_nxt);

  // ==========================================================
  // Mode and captured state.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_r <= opmode_pkg::MODE_BOOT;
      pc_hold_r <= '0;
      icg_keep_r <= 1'b0;
      dbg_keep_r <= 1'b0;
      lvd_keep_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      pc_hold_r <= pc_hold_nxt;
      icg_keep_r <= icg_keep_nxt;
      dbg_keep_r <= dbg_keep_nxt;
      lvd_keep_r <= lvd_keep_nxt;
    end
  end

  // ==========================================================
  // Program counter and reset requests; the pin reset stays up while the pin is held in stop, the rest are one-cycle pulses.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pc_load_r <= 1'b0;
      pc_load_addr_r <= opmode_pkg::RESET_PC;
      ilop_reset_r <= 1'b0;
      pin_reset_r <= 1'b0;
      trace_step_r <= 1'b0;
    end else begin
      pc_load_r <= load_boot || load_resume;
      pc_load_addr_r <= pc_load_nxt;
      ilop_reset_r <= (mode_r == opmode_pkg::MODE_RUN) && !run_to_dbg && !wait_exec &&
                      stop_exec && !stop_enable_bit;
      pin_reset_r <= (mode_r == opmode_pkg::MODE_STOP) && reset_pin_asserted;
      trace_step_r <= (mode_r == opmode_pkg::MODE_DEBUG) && trace_ok;
    end
  end

  // ==========================================================
  // Clock, power and pin-hold enables.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cpu_run_r <= 1'b0;
      periph_clk_en_r <= 1'b1;
      clock_gen_on_r <= 1'b1;
      regulator_full_r <= 1'b1;
      debug_clk_en_r <= 1'b1;
      pin_hold_r <= 1'b0;
      wake_clk_en_r <= 1'b0;
      ext_ref_on_r <= 1'b1;
      adc_active_r <= 1'b1;
      lcd_active_r <= 1'b1;
    end else begin
      cpu_run_r <= cpu_run_nxt;
      periph_clk_en_r <= !in_stop;
      clock_gen_on_r <= clock_gen_nxt;
      regulator_full_r <= reg_full_nxt;
      debug_clk_en_r <= dbg_clk_nxt;
      pin_hold_r <= in_stop;
      wake_clk_en_r <= (periodic_wake_select != opmode_pkg::PWAKE_OFF);
      ext_ref_on_r <= ext_ref_nxt;
      adc_active_r <= adc_nxt;
      lcd_active_r <= lcd_nxt;
    end
  end

  // ==========================================================
  // Command answers, one-cycle pulses. A status access in wait, or in stop
  // with debug kept, is answered but never touches memory.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_accept_r <= 1'b0;
      cmd_reject_r <= 1'b0;
      cmd_stat_err_r <= 1'b0;
      mem_access_r <= 1'b0;
    end else begin
      cmd_accept_r <= cif.accept;
      cmd_reject_r <= cif.reject;
      cmd_stat_err_r <= cif.stat_err;
      mem_access_r <= cif.accept && !cif.stat_err &&
                      ((dbg_cmd_code == opmode_pkg::CMD_MEM) ||
                       (dbg_cmd_code == opmode_pkg::CMD_MEM_STAT));
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_boot_high;
    (mode_r == opmode_pkg::MODE_BOOT) && mode_select_debug_pin;
  endsequence

  sequence s_wait_request;
    (mode_r == opmode_pkg::MODE_RUN) && !run_to_dbg && wait_exec;
  endsequence

  sequence s_wait_irq;
    (mode_r == opmode_pkg::MODE_WAIT) && !halt_to_debug_instruction_ok && irq_request;
  endsequence

  chk_boot_run_sel: assert property (s_boot_high |=> (mode_r == opmode_pkg::MODE_RUN) &&
    pc_load_r && (pc_load_addr_r == 14'h3FFD) && cpu_run_r)
    else $error("boot with pin high did not start run at reset address");

  chk_boot_dbg_sel: assert property ((mode_r == opmode_pkg::MODE_BOOT) && !mode_select_debug_pin
    |=> (mode_r == opmode_pkg::MODE_DEBUG) && !cpu_run_r)
    else $error("boot with pin low did not enter debug mode");

  chk_debug_cpu_hold: assert property ((mode_r == opmode_pkg::MODE_DEBUG) |-> !cpu_run_r)
    else $error("CPU running in debug mode");

  chk_run_cmd_gate: assert property ((mode_r == opmode_pkg::MODE_RUN) && dbg_cmd_valid &&
    (dbg_cmd_code == opmode_pkg::CMD_GO || dbg_cmd_code == opmode_pkg::CMD_CPU_REG)
    |=> cmd_reject_r && !cmd_accept_r && (mode_r != opmode_pkg::MODE_DEBUG))
    else $error("debug-only command taken in run mode");

  chk_run_nonintr: assert property ((mode_r == opmode_pkg::MODE_RUN) && dbg_cmd_valid &&
    (dbg_cmd_code == opmode_pkg::CMD_MEM) |=> cmd_accept_r && mem_access_r)
    else $error("memory command refused in run mode");

  chk_wait_entry: assert property (s_wait_request |=> (mode_r == opmode_pkg::MODE_WAIT) &&
    !cpu_run_r && (pc_hold_r == $past(cpu_pc)))
    else $error("wait entry did not stop CPU or hold PC");

  chk_wait_resume: assert property (s_wait_irq |=> (mode_r == opmode_pkg::MODE_RUN) &&
    pc_load_r && (pc_load_addr_r == $past(pc_hold_r) + 14'h0001))
    else $error("wait exit did not resume at held PC plus one");

  chk_wait_stat_err: assert property ((mode_r == opmode_pkg::MODE_WAIT) && dbg_cmd_valid &&
    (dbg_cmd_code == opmode_pkg::CMD_MEM_STAT) |=> cmd_stat_err_r && !mem_access_r)
    else $error("status access in wait not flagged");

  chk_stop_illegal: assert property ((mode_r == opmode_pkg::MODE_RUN) && !run_to_dbg &&
    !wait_exec && stop_exec && !stop_enable_bit |=> ilop_reset_r ##1 !ilop_reset_r)
    else $error("disabled stop did not force one reset pulse");

  chk_stop_clocks: assert property ((mode_r == opmode_pkg::MODE_STOP) |->
    !periph_clk_en_r && !cpu_run_r && pin_hold_r)
    else $error("clocks alive in stop mode");

  chk_pwake_off: assert property ((periodic_wake_select == 3'h0) |=> !wake_clk_en_r)
    else $error("periodic wake clock on with select zero");

  chk_dbg_stop_reg: assert property ((mode_r == opmode_pkg::MODE_STOP) && dbg_keep_r |->
    regulator_full_r && debug_clk_en_r)
    else $error("debug-enabled stop lost debug clocks or regulation");

endmodule
`default_nettype wire

// *** hdl/opmode_pkg.sv ***
// Package of constants and types for the operating-mode controller.
package opmode_pkg;

  // ==========================================================
  // Program counter
  localparam int PC_W = 14;
  localparam logic [13:0] RESET_PC = 14'h3FFD;
  localparam logic [13:0] PC_STEP = 14'h0001;

  // ==========================================================
  // Periodic wake select value that switches the function off
  localparam int PWAKE_SEL_W = 3;
  localparam logic [2:0] PWAKE_OFF = 3'h0;

  // ==========================================================
  // Operating modes
  typedef enum logic [2:0] {
    MODE_BOOT  = 3'b000,
    MODE_RUN   = 3'b001,
    MODE_DEBUG = 3'b010,
    MODE_WAIT  = 3'b011,
    MODE_STOP  = 3'b100
  } op_mode_t;

  // ==========================================================
  // Debug command classes as delivered by the serial front end
  typedef enum logic [2:0] {
    CMD_MEM      = 3'b000,
    CMD_MEM_STAT = 3'b001,
    CMD_HALT_TO_DEBUG_INSTRUCTION     = 3'b010,
    CMD_CPU_REG  = 3'b011,
    CMD_TRACE    = 3'b100,
    CMD_GO       = 3'b101
  } dbg_cmd_t;

endpackage
